// >>> pkg/cwa_defines.vh
// Summary of operation
// [RQ1] code 12: count up on increment rising edge, down on decrement edge.
// [RQ2] code 13: target bit ON for one scan after input goes OFF to ON.
// [RQ3] code 14: target bit ON for one scan after input goes ON to OFF.
// [RQ4] code 16: shift words start..end up one place, zero the start word.
// [RQ5] code 20: compare two words, report only via above, match, below flags.
// [RQ6] code 21: copy source word or constant unchanged to destination.
// [RQ7] code 22: copy bitwise inverted source to destination.
// [RQ8] code 23: convert four-digit BCD word to 16-bit binary result.
// [RQ9] code 24: convert binary word to BCD result.
// [RQ10] codes 25, 26: shift word left or right one bit through carry.
// [RQ11] codes 27, 28: rotate word left or right one bit through carry.
// [RQ12] code 29: invert every bit of the addressed word.
// [RQ13] code 30: BCD add two words plus carry into result word.
// [RQ14] code 31: BCD subtract word and carry from another word.
// [RQ15] code 32: BCD multiply two words into two result words.
// [RQ16] code 33: BCD divide dividend by divisor into result words.
// [RQ17] code 34: result bit set where both input bits are ON.
// [RQ18] code 35: result bit set where either input bit is ON.
// [RQ19] code 36: result bit set where input bits differ.
// [RQ20] code 37: result bit set where input bits are equal.
// [RQ21] codes 38, 39: BCD increment or decrement a word, staying BCD.
// [RQ22] code 40 forces carry ON, code 41 forces it OFF, nothing else.
// [RQ23] codes 17 to 19 and unassigned codes do nothing.
`ifndef CWA_DEFINES_VH
`define CWA_DEFINES_VH
////////////////////////////////////////////////////////////////////////////
// register byte offsets
`define CWA_OFS_CMD     8'h00
`define CWA_OFS_OPA     8'h04
`define CWA_OFS_OPB     8'h08
`define CWA_OFS_RES     8'h0C
`define CWA_OFS_RESHI   8'h10
`define CWA_OFS_FLAGS   8'h14
`define CWA_OFS_COUNT   8'h18
`define CWA_OFS_MADDR   8'h1C
`define CWA_OFS_MDATA   8'h20
// flag register bit positions
`define CWA_FLG_CARRY   0
`define CWA_FLG_ABOVE   1
`define CWA_FLG_MATCH   2
`define CWA_FLG_BELOW   3
`define CWA_FLG_RISE    4
`define CWA_FLG_FALL    5
`define CWA_FLG_ERR     6
`define CWA_FLG_BUSY    8
// operand bit positions for edge inputs
`define CWA_IN_INC      0
`define CWA_IN_DEC      1
`define CWA_IN_SIG      0
// reset values
`define CWA_RST_WORD    16'h0000
`define CWA_RST_CODE    6'h00
// function codes
`define CWA_FN_COUNT    6'h0C
`define CWA_FN_RISE     6'h0D
`define CWA_FN_FALL     6'h0E
`define CWA_FN_WSHIFT   6'h10
`define CWA_FN_COMPARE  6'h14
`define CWA_FN_MOV      6'h15
`define CWA_FN_MOVINV   6'h16
`define CWA_FN_TOBIN    6'h17
`define CWA_FN_TOBCD    6'h18
`define CWA_FN_SHL      6'h19
`define CWA_FN_SHR      6'h1A
`define CWA_FN_ROL      6'h1B
`define CWA_FN_ROR      6'h1C
`define CWA_FN_INV      6'h1D
`define CWA_FN_ADD      6'h1E
`define CWA_FN_SUB      6'h1F
`define CWA_FN_MUL      6'h20
`define CWA_FN_DIV      6'h21
`define CWA_FN_AND      6'h22
`define CWA_FN_OR       6'h23
`define CWA_FN_XOR      6'h24
`define CWA_FN_XNOR     6'h25
`define CWA_FN_INC      6'h26
`define CWA_FN_DEC      6'h27
`define CWA_FN_SETC     6'h28
`define CWA_FN_CLRC     6'h29
// dabble step count, bcd conversion limit, divide scale factor
`define CWA_DAB_STEPS   6'h20
`define CWA_BCD_MAX     16'h270F
`define CWA_DIV_SCALE   32'h00002710
`endif

// >>> core/cwa_bcd_digit.v
`timescale 1ns/1ps
`default_nettype none
// one decimal digit of the bcd adder
module cwa_bcd_digit (
  // operands
  input  wire [3:0] i_a,
  input  wire [3:0] i_b,
  input  wire       i_ci,
  // sum
  output wire [3:0] o_s,
  output wire       o_co
);
  wire [4:0] raw;
  wire [4:0] fix;
  // binary sum, then decimal adjust above nine
  assign raw  = {1'b0, i_a} + {1'b0, i_b} + {4'h0, i_ci};
  assign fix  = raw + 5'h06;
  assign o_co = (raw > 5'h09);
  assign o_s  = o_co ? fix[3:0] : raw[3:0];
endmodule // cwa_bcd_digit
`default_nettype wire

// >>> core/cwa_word_mem.v
`timescale 1ns/1ps
`default_nettype none
// word store with registered read data
module cwa_word_mem #(
  parameter W  = 16,
  parameter AW = 4
) (
  // clock
  input  wire          i_clk,
  input  wire          i_rst,
  input  wire          i_en,
  // write port
  input  wire          i_we,
  input  wire [AW-1:0] i_waddr,
  input  wire [W-1:0]  i_wdata,
  // read port
  input  wire [AW-1:0] i_raddr,
  output reg  [W-1:0]  o_rdata
);
  reg [W-1:0] mem [0:(1<<AW)-1];
  // write and registered read
  always @(posedge i_clk) begin
    if (i_en) begin
      if (i_we) begin
        mem[i_waddr] <= i_wdata;
      end
    end
  end
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= {W{1'b0}};
    end else if (i_en) begin
      o_rdata <= mem[i_raddr];
    end
  end
endmodule // cwa_word_mem
`default_nettype wire

// >>> core/cwa_word_alu.v
`timescale 1ns/1ps
`default_nettype none
`include "cwa_defines.vh"
module cwa_word_alu #(
  parameter AW = 4
) (
  // clock, reset, enable
  input  wire        I_CLK,
  input  wire        I_SYS_RST,
  input  wire        I_CLK_EN,
  // axi4-lite write
  input  wire [7:0]  I_AWADDR,
  input  wire        I_AWVALID,
  output wire        O_AWREADY,
  input  wire [31:0] I_WDATA,
  input  wire [3:0]  I_WSTRB,
  input  wire        I_WVALID,
  output wire        O_WREADY,
  output wire [1:0]  O_BRESP,
  output wire        O_BVALID,
  input  wire        I_BREADY,
  // axi4-lite read
  input  wire [7:0]  I_ARADDR,
  input  wire        I_ARVALID,
  output wire        O_ARREADY,
  output wire [31:0] O_RDATA,
  output wire [1:0]  O_RRESP,
  output wire        O_RVALID,
  input  wire        I_RREADY,
  // status
  output wire        O_BUSY
);
  localparam S_IDLE = 2'h0;
  localparam S_SHRD = 2'h1;
  localparam S_SHWR = 2'h2;
  localparam S_DAB  = 2'h3;
  localparam K_CONV = 2'h0;
  localparam K_MUL  = 2'h1;
  localparam K_DIV  = 2'h2;

  reg         awready_ff, wready_ff, bvalid_ff, aw_full_ff, w_full_ff;
  reg  [1:0]  bresp_ff;
  reg  [7:0]  awaddr_ff;
  reg  [31:0] wdata_ff;
  reg  [3:0]  wstrb_ff;
  reg         arready_ff, rvalid_ff;
  reg  [1:0]  rresp_ff;
  reg  [31:0] rdata_ff;
  reg  [15:0] opa_ff, opb_ff, res_ff, reshi_ff, count_ff;
  reg  [AW-1:0] maddr_ff;
  reg  [5:0]  code_ff;
  reg         launch_ff, busy_ff;
  reg         carry_ff, above_ff, match_ff, below_ff, rise_ff, fall_ff;
  reg         err_ff, inc_prev_ff, dec_prev_ff, rise_prev_ff, fall_prev_ff;
  reg  [1:0]  state_ff, kind_ff;
  reg  [AW-1:0] ptr_ff, start_ff;
  reg  [31:0] bin_ff, bcd_ff;
  reg  [5:0]  step_ff;
  wire [15:0] mem_rdata;

  ////////////////////////////////////////////////////////////////////////
  // helper functions
  function valid_bcd;
    input [15:0] v;
    begin
      valid_bcd = (v[3:0] < 4'hA) && (v[7:4] < 4'hA) &&
                  (v[11:8] < 4'hA) && (v[15:12] < 4'hA);
    end
  endfunction
  function [15:0] bcd_to_bin;
    input [15:0] v;
    begin
      bcd_to_bin = {12'h000, v[15:12]} * 16'h03E8 +
                   {12'h000, v[11:8]} * 16'h0064 +
                   {12'h000, v[7:4]} * 16'h000A + {12'h000, v[3:0]};
    end
  endfunction
  function [15:0] nines;
    input [15:0] v;
    begin
      nines = 16'h9999 - v;
    end
  endfunction
  function [31:0] dab_adjust;
    input [31:0] v;
    integer k;
    begin
      dab_adjust = v;
      for (k = 0; k < 8; k = k + 1) begin
        if (v[k*4 +: 4] > 4'h4) begin
          dab_adjust[k*4 +: 4] = v[k*4 +: 4] + 4'h3;
        end
      end
    end
  endfunction
  function [15:0] lane_merge;
    input [15:0] old;
    input [31:0] data;
    input [3:0]  strb;
    begin
      lane_merge = {strb[1] ? data[15:8] : old[15:8],
                    strb[0] ? data[7:0] : old[7:0]};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // bcd adder chain shared by add, subtract, increment, decrement
  reg  [15:0] add_b;
  reg         add_ci;
  wire [4:0]  chain;
  wire [15:0] add_sum;
  always @* begin
    add_b  = opb_ff;
    add_ci = carry_ff;
    case (code_ff)
      `CWA_FN_SUB: begin
        add_b  = nines(opb_ff);
        add_ci = ~carry_ff;
      end
      `CWA_FN_INC: begin
        add_b  = 16'h0000;
        add_ci = 1'b1;
      end
      `CWA_FN_DEC: begin
        add_b  = 16'h9999;
        add_ci = 1'b0;
      end
      default: begin
        add_b  = opb_ff;
        add_ci = carry_ff;
      end
    endcase
  end
  assign chain[0] = add_ci;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_dig
      cwa_bcd_digit u_dig (
        .i_a  (opa_ff[g*4 +: 4]),
        .i_b  (add_b[g*4 +: 4]),
        .i_ci (chain[g]),
        .o_s  (add_sum[g*4 +: 4]),
        .o_co (chain[g+1])
      );
    end
  endgenerate

  // binary products and quotients for the slow bcd ops
  wire [15:0] a_bin = bcd_to_bin(opa_ff);
  wire [15:0] b_bin = bcd_to_bin(opb_ff);
  wire [31:0] prod  = {16'h0000, a_bin} * {16'h0000, b_bin};
  wire        b_zero = (b_bin == 16'h0000);
  wire [15:0] quo   = b_zero ? 16'h0000 : a_bin / b_bin;
  wire [15:0] rem   = b_zero ? 16'h0000 : a_bin % b_bin;
  wire [31:0] qr    = {16'h0000, quo} * `CWA_DIV_SCALE + {16'h0000, rem};
  wire        ab_ok = valid_bcd(opa_ff) && valid_bcd(opb_ff);

  ////////////////////////////////////////////////////////////////////////
  // axi write channel handshake
  wire aw_take = I_AWVALID & awready_ff;
  wire w_take  = I_WVALID & wready_ff;
  wire aw_have = aw_full_ff | aw_take;
  wire w_have  = w_full_ff | w_take;
  wire commit  = aw_have & w_have & ~bvalid_ff;
  wire [7:0]  wa = aw_full_ff ? awaddr_ff : I_AWADDR;
  wire [31:0] wd = w_full_ff ? wdata_ff : I_WDATA;
  wire [3:0]  ws = w_full_ff ? wstrb_ff : I_WSTRB;
  wire nxt_aw_full = aw_have & ~commit;
  wire nxt_w_full  = w_have & ~commit;
  wire nxt_bvalid  = commit | (bvalid_ff & ~I_BREADY);
  wire idle_now    = (state_ff == S_IDLE) & ~launch_ff;
  wire wa_map = (wa == `CWA_OFS_CMD) || (wa == `CWA_OFS_OPA) ||
                (wa == `CWA_OFS_OPB) || (wa == `CWA_OFS_RES) ||
                (wa == `CWA_OFS_RESHI) || (wa == `CWA_OFS_FLAGS) ||
                (wa == `CWA_OFS_COUNT) || (wa == `CWA_OFS_MADDR) ||
                (wa == `CWA_OFS_MDATA);
  wire wr_cmd  = commit & (wa == `CWA_OFS_CMD) & ws[0] & idle_now;
  wire wr_mem  = commit & (wa == `CWA_OFS_MDATA) & idle_now;
  always @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
      aw_full_ff <= 1'b0;
      w_full_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= 2'h0;
      awaddr_ff  <= 8'h00;
      wdata_ff   <= 32'h00000000;
      wstrb_ff   <= 4'h0;
    end else if (I_CLK_EN) begin
      aw_full_ff <= nxt_aw_full;
      w_full_ff  <= nxt_w_full;
      bvalid_ff  <= nxt_bvalid;
      awready_ff <= ~nxt_aw_full & ~nxt_bvalid;
      wready_ff  <= ~nxt_w_full & ~nxt_bvalid;
      if (aw_take) begin
        awaddr_ff <= I_AWADDR;
      end
      if (w_take) begin
        wdata_ff <= I_WDATA;
        wstrb_ff <= I_WSTRB;
      end
      if (commit) begin
        bresp_ff <= wa_map ? 2'h0 : 2'h2; // slverr on unmapped
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi read channel
  reg [31:0] rmux;
  reg        rmap;
  always @* begin
    rmap = 1'b1;
    case (I_ARADDR)
      `CWA_OFS_CMD:   rmux = {26'h0, code_ff};
      `CWA_OFS_OPA:   rmux = {16'h0000, opa_ff};
      `CWA_OFS_OPB:   rmux = {16'h0000, opb_ff};
      `CWA_OFS_RES:   rmux = {16'h0000, res_ff};
      `CWA_OFS_RESHI: rmux = {16'h0000, reshi_ff};
      `CWA_OFS_FLAGS: rmux = {23'h0, busy_ff, 1'b0, err_ff, fall_ff,
                              rise_ff, below_ff, match_ff, above_ff,
                              carry_ff};
      `CWA_OFS_COUNT: rmux = {16'h0000, count_ff};
      `CWA_OFS_MADDR: rmux = {{(32-AW){1'b0}}, maddr_ff};
      `CWA_OFS_MDATA: rmux = {16'h0000, mem_rdata};
      default: begin
        rmux = 32'h00000000;
        rmap = 1'b0;
      end
    endcase
  end
  always @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rresp_ff   <= 2'h0;
      rdata_ff   <= 32'h00000000;
    end else if (I_CLK_EN) begin
      if (I_ARVALID & arready_ff) begin
        arready_ff <= 1'b0;
        rvalid_ff  <= 1'b1;
        rdata_ff   <= rmux;
        rresp_ff   <= rmap ? 2'h0 : 2'h2;
      end else if (rvalid_ff & I_RREADY) begin
        rvalid_ff  <= 1'b0;
        arready_ff <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // word store, shared by software and the word shift sequence
  wire          shift_zero = (state_ff == S_SHRD) & (ptr_ff == start_ff);
  wire          mem_we = wr_mem | shift_zero | (state_ff == S_SHWR);
  wire [AW-1:0] mem_wa = wr_mem ? maddr_ff : ptr_ff;
  wire [15:0]   mem_wd = wr_mem ? wd[15:0] :
                         (shift_zero ? `CWA_RST_WORD : mem_rdata);
  wire [AW-1:0] mem_ra = (state_ff == S_SHRD) ? ptr_ff - 1'b1 : maddr_ff;
  cwa_word_mem #(
    .W  (16),
    .AW (AW)
  ) u_mem (
    .i_clk   (I_CLK),
    .i_rst   (I_SYS_RST),
    .i_en    (I_CLK_EN),
    .i_we    (mem_we),
    .i_waddr (mem_wa),
    .i_wdata (mem_wd),
    .i_raddr (mem_ra),
    .o_rdata (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // instruction execution and sequencing
  wire inc_edge = opa_ff[`CWA_IN_INC] & ~inc_prev_ff;
  wire dec_edge = opa_ff[`CWA_IN_DEC] & ~dec_prev_ff;
  wire [31:0] dab_v = dab_adjust(bcd_ff);
  always @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      opa_ff <= `CWA_RST_WORD;  opb_ff <= `CWA_RST_WORD;
      res_ff <= `CWA_RST_WORD;  reshi_ff <= `CWA_RST_WORD;
      count_ff <= `CWA_RST_WORD;
      maddr_ff <= {AW{1'b0}};
      code_ff <= `CWA_RST_CODE;
      launch_ff <= 1'b0;  busy_ff <= 1'b0;
      carry_ff <= 1'b0;  above_ff <= 1'b0;  match_ff <= 1'b0;
      below_ff <= 1'b0;  rise_ff <= 1'b0;   fall_ff <= 1'b0;
      err_ff <= 1'b0;
      inc_prev_ff <= 1'b0;  dec_prev_ff <= 1'b0;
      rise_prev_ff <= 1'b0; fall_prev_ff <= 1'b0;
      state_ff <= S_IDLE;  kind_ff <= K_CONV;
      ptr_ff <= {AW{1'b0}};  start_ff <= {AW{1'b0}};
      bin_ff <= 32'h00000000;  bcd_ff <= 32'h00000000;
      step_ff <= 6'h00;
    end else if (I_CLK_EN) begin
      busy_ff   <= wr_cmd | launch_ff | (state_ff != S_IDLE);
      launch_ff <= wr_cmd;
      // software register writes
      if (commit & (wa == `CWA_OFS_CMD) & idle_now)
        code_ff <= ws[0] ? wd[5:0] : code_ff;
      if (commit & (wa == `CWA_OFS_OPA))
        opa_ff <= lane_merge(opa_ff, wd, ws);
      if (commit & (wa == `CWA_OFS_OPB))
        opb_ff <= lane_merge(opb_ff, wd, ws);
      if (commit & (wa == `CWA_OFS_COUNT))
        count_ff <= lane_merge(count_ff, wd, ws);
      if (commit & (wa == `CWA_OFS_MADDR) & ws[0])
        maddr_ff <= wd[AW-1:0];
      if (commit & (wa == `CWA_OFS_FLAGS) & ws[0] & idle_now)
        carry_ff <= wd[`CWA_FLG_CARRY];
      case (state_ff)
        S_IDLE: begin
          if (launch_ff) begin
            err_ff <= 1'b0;
            case (code_ff)
              // edge counting
              `CWA_FN_COUNT: begin
                // [RQ1] edge up/down count
                count_ff <= count_ff + {15'h0000, inc_edge}
                            - {15'h0000, dec_edge};
                inc_prev_ff <= opa_ff[`CWA_IN_INC];
                dec_prev_ff <= opa_ff[`CWA_IN_DEC];
              end
              `CWA_FN_RISE: begin
                // [RQ2] rising edge pulse
                rise_ff <= opa_ff[`CWA_IN_SIG] & ~rise_prev_ff;
                rise_prev_ff <= opa_ff[`CWA_IN_SIG];
              end
              `CWA_FN_FALL: begin
                // [RQ3] falling edge pulse
                fall_ff <= ~opa_ff[`CWA_IN_SIG] & fall_prev_ff;
                fall_prev_ff <= opa_ff[`CWA_IN_SIG];
              end
              `CWA_FN_WSHIFT: begin
                // [RQ4] start word range shift
                if (opa_ff[AW-1:0] > opb_ff[AW-1:0]) begin
                  err_ff <= 1'b1;
                end else begin
                  start_ff <= opa_ff[AW-1:0];
                  ptr_ff   <= opb_ff[AW-1:0];
                  state_ff <= S_SHRD;
                end
              end
              `CWA_FN_COMPARE: begin
                // [RQ5] flags only, result untouched
                above_ff <= (opa_ff > opb_ff);
                match_ff <= (opa_ff == opb_ff);
                below_ff <= (opa_ff < opb_ff);
              end
              // [RQ6] plain copy
              `CWA_FN_MOV:    res_ff <= opa_ff;
              // [RQ7] inverted copy
              `CWA_FN_MOVINV: res_ff <= ~opa_ff;
              `CWA_FN_TOBIN: begin
                // [RQ8] bcd to binary
                if (valid_bcd(opa_ff)) res_ff <= a_bin;
                else err_ff <= 1'b1;
              end
              `CWA_FN_TOBCD: begin
                // [RQ9] binary to bcd via dabble
                if (opa_ff > `CWA_BCD_MAX) begin
                  err_ff <= 1'b1;
                end else begin
                  bin_ff <= {16'h0000, opa_ff};
                  kind_ff <= K_CONV;
                  state_ff <= S_DAB;
                end
              end
              // [RQ10] shift through carry
              `CWA_FN_SHL: begin
                res_ff <= {opa_ff[14:0], 1'b0};
                carry_ff <= opa_ff[15];
              end
              `CWA_FN_SHR: begin
                res_ff <= {1'b0, opa_ff[15:1]};
                carry_ff <= opa_ff[0];
              end
              // [RQ11] rotate through carry
              `CWA_FN_ROL: begin
                res_ff <= {opa_ff[14:0], carry_ff};
                carry_ff <= opa_ff[15];
              end
              `CWA_FN_ROR: begin
                res_ff <= {carry_ff, opa_ff[15:1]};
                carry_ff <= opa_ff[0];
              end
              // [RQ12] complement word
              `CWA_FN_INV:  res_ff <= ~opa_ff;
              `CWA_FN_ADD, `CWA_FN_SUB: begin
                // [RQ13] [RQ14] bcd add or subtract with carry
                if (ab_ok) begin
                  res_ff <= add_sum;
                  carry_ff <= (code_ff == `CWA_FN_ADD) ? chain[4]
                                                        : ~chain[4];
                end else begin
                  err_ff <= 1'b1;
                end
              end
              `CWA_FN_MUL: begin
                // [RQ15] product to two words
                if (ab_ok) begin
                  bin_ff <= prod;
                  kind_ff <= K_MUL;
                  state_ff <= S_DAB;
                end else begin
                  err_ff <= 1'b1;
                end
              end
              `CWA_FN_DIV: begin
                // [RQ16] quotient and remainder
                if (ab_ok & ~b_zero) begin
                  bin_ff <= qr;
                  kind_ff <= K_DIV;
                  state_ff <= S_DAB;
                end else begin
                  err_ff <= 1'b1;
                end
              end
              // [RQ17] bitwise and
              `CWA_FN_AND:  res_ff <= opa_ff & opb_ff;
              // [RQ18] bitwise or
              `CWA_FN_OR:   res_ff <= opa_ff | opb_ff;
              // [RQ19] bitwise difference
              `CWA_FN_XOR:  res_ff <= opa_ff ^ opb_ff;
              // [RQ20] bitwise sameness
              `CWA_FN_XNOR: res_ff <= ~(opa_ff ^ opb_ff);
              `CWA_FN_INC, `CWA_FN_DEC: begin
                // [RQ21] bcd step, carry kept
                if (valid_bcd(opa_ff)) res_ff <= add_sum;
                else err_ff <= 1'b1;
              end
              // [RQ22] carry force
              `CWA_FN_SETC: carry_ff <= 1'b1;
              `CWA_FN_CLRC: carry_ff <= 1'b0;
              // [RQ23] unassigned codes idle
              default: err_ff <= 1'b0;
            endcase
            bcd_ff  <= 32'h00000000;
            step_ff <= `CWA_DAB_STEPS;
          end
        end
        S_SHRD: begin
          // [RQ4] zero the start word when reached
          if (ptr_ff == start_ff) state_ff <= S_IDLE;
          else state_ff <= S_SHWR;
        end
        S_SHWR: begin
          ptr_ff   <= ptr_ff - 1'b1;
          state_ff <= S_SHRD;
        end
        S_DAB: begin
          bcd_ff  <= {dab_v[30:0], bin_ff[31]};
          bin_ff  <= {bin_ff[30:0], 1'b0};
          step_ff <= step_ff - 6'h01;
          if (step_ff == 6'h01) begin
            state_ff <= S_IDLE;
            case (kind_ff)
              K_MUL: begin
                res_ff   <= {dab_v[14:0], bin_ff[31]};
                reshi_ff <= dab_v[30:15];
              end
              K_DIV: begin
                res_ff   <= dab_v[30:15];
                reshi_ff <= {dab_v[14:0], bin_ff[31]};
              end
              default: res_ff <= {dab_v[14:0], bin_ff[31]};
            endcase
          end
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from flops
  assign O_AWREADY = awready_ff;
  assign O_WREADY  = wready_ff;
  assign O_BVALID  = bvalid_ff;
  assign O_BRESP   = bresp_ff;
  assign O_ARREADY = arready_ff;
  assign O_RVALID  = rvalid_ff;
  assign O_RRESP   = rresp_ff;
  assign O_RDATA   = rdata_ff;
  assign O_BUSY    = busy_ff;
endmodule // cwa_word_alu
`default_nettype wire

// >>> verif/cwa_props_properties.sv
`timescale 1ns/1ps
`default_nettype none
// bus handshake and busy timing checks
module cwa_props (
  input wire logic        I_CLK, I_SYS_RST, I_AWVALID, O_AWREADY,
  input wire logic        I_WVALID, O_WREADY, O_BVALID, I_BREADY,
  input wire logic        I_ARVALID, O_ARREADY, O_RVALID, I_RREADY,
  input wire logic        O_BUSY,
  input wire logic [7:0]  I_AWADDR,
  input wire logic [3:0]  I_WSTRB,
  input wire logic [1:0]  O_BRESP,
  input wire logic [31:0] O_RDATA
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  // address and data taken on one edge
  sequence s_wr_take;
    I_AWVALID && O_AWREADY && I_WVALID && O_WREADY;
  endsequence
  // port idle again after a response
  sequence s_b_free;
    !O_BVALID && O_AWREADY && O_WREADY;
  endsequence
  a_wr_answer: assert property (s_wr_take |=> O_BVALID)
    else $error("write not answered");
  a_b_release: assert property (O_BVALID && I_BREADY |=> s_b_free)
    else $error("write port not freed");
  a_b_hold: assert property (O_BVALID && !I_BREADY |=>
    O_BVALID && $stable(O_BRESP)) else $error("write response dropped");
  a_ready_low: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
    else $error("ready during response");
  a_rd_answer: assert property (I_ARVALID && O_ARREADY |=>
    O_RVALID && !O_ARREADY) else $error("read not answered");
  a_r_hold: assert property (O_RVALID && !I_RREADY |=>
    O_RVALID && $stable(O_RDATA)) else $error("read data dropped");
  a_r_release: assert property (O_RVALID && I_RREADY |=>
    !O_RVALID && O_ARREADY) else $error("read port not freed");
  a_cmd_busy: assert property (s_wr_take ##0 (I_AWADDR == 8'h00 &&
    I_WSTRB[0] && !O_BUSY) |=> O_BUSY) else $error("launch not busy");
  a_busy_bound: assert property ($rose(O_BUSY) |-> ##[1:60] !O_BUSY)
    else $error("busy too long");
endmodule // cwa_props
bind cwa_word_alu cwa_props u_props (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST),
  .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY), .I_WVALID(I_WVALID),
  .O_WREADY(O_WREADY), .O_BVALID(O_BVALID), .I_BREADY(I_BREADY),
  .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RVALID(O_RVALID),
  .I_RREADY(I_RREADY), .O_BUSY(O_BUSY), .I_AWADDR(I_AWADDR),
  .I_WSTRB(I_WSTRB), .O_BRESP(O_BRESP), .O_RDATA(O_RDATA));
`default_nettype wire

// >>> verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk = 1'h0, rst = 1'h1, awv = 1'h0, wv = 1'h0;
  logic        bry = 1'h0, arv = 1'h0, rry = 1'h0;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, d;
  logic [1:0]  bs, rs;
  wire  [31:0] rdat;
  wire  [1:0]  br, rr;
  wire         awr, wrd, bv, arr, rv, busy;
  int          fail_count = 0, n_tests = 0, cyc = 0;
  // block under test
  cwa_word_alu dut_u (.I_CLK(clk), .I_SYS_RST(rst), .I_CLK_EN(1'h1),
    .I_AWADDR(awa), .I_AWVALID(awv), .O_AWREADY(awr), .I_WDATA(wd),
    .I_WSTRB(4'h3), .I_WVALID(wv), .O_WREADY(wrd), .O_BRESP(br),
    .O_BVALID(bv), .I_BREADY(bry), .I_ARADDR(ara), .I_ARVALID(arv),
    .O_ARREADY(arr), .O_RDATA(rdat), .O_RRESP(rr), .O_RVALID(rv),
    .I_RREADY(rry), .O_BUSY(busy));
  // clock and hang guard
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      summarize;
    end
  end
  // bus write, response accepted one cycle late
  task automatic wr(input [7:0] a, input [15:0] v);
    awa <= a; wd <= {16'h0000, v}; awv <= 1'h1; wv <= 1'h1;
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 1'h0;
      if (wv && wrd) wv <= 1'h0;
    end while (!bv);
    bry <= 1'h1;
    @(posedge clk);
    bs = br;
    bry <= 1'h0;
  endtask
  // bus read into d and rs
  task automatic rd(input [7:0] a);
    ara <= a; arv <= 1'h1;
    do begin
      @(posedge clk);
      if (arv && arr) arv <= 1'h0;
    end while (!rv);
    rry <= 1'h1;
    @(posedge clk);
    d = rdat; rs = rr;
    rry <= 1'h0;
  endtask
  task automatic ck(input [31:0] g, e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // load operands, launch, wait for idle
  task automatic op(input [5:0] c, input [15:0] a, b);
    wr(8'h04, a); wr(8'h08, b); wr(8'h00, {10'h000, c});
    @(posedge clk);
    while (busy) @(posedge clk);
  endtask
  task automatic t(input [5:0] c, input [15:0] a, b, e);
    op(c, a, b); rd(8'h0C); ck(d, {16'h0000, e});
  endtask
  task automatic cy(input e);
    rd(8'h14); ck(d[0], e);
  endtask
  task automatic summarize;
    $display("mismatches %0d, checks %0d", fail_count, n_tests);
    if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    t(6'h22, 16'hF0A5, 16'h3C3C, 16'h3024);
    t(6'h23, 16'hF0A5, 16'h3C3C, 16'hFCBD);
    t(6'h24, 16'hF0A5, 16'h3C3C, 16'hCC99);
    t(6'h25, 16'hF0A5, 16'h3C3C, 16'h3366);
    t(6'h15, 16'hF0A5, 16'h0000, 16'hF0A5);
    t(6'h16, 16'hF0A5, 16'h0000, 16'h0F5A);
    t(6'h1D, 16'h00FF, 16'h0000, 16'hFF00);
    t(6'h12, 16'h0005, 16'h0000, 16'hFF00);
    t(6'h17, 16'h1234, 16'h0000, 16'h04D2);
    t(6'h18, 16'h270F, 16'h0000, 16'h9999);
    op(6'h28, 16'h0000, 16'h0000); cy(1'h1);
    t(6'h1B, 16'h8001, 16'h0000, 16'h0003); cy(1'h1);
    op(6'h29, 16'h0000, 16'h0000); cy(1'h0);
    t(6'h1C, 16'h8001, 16'h0000, 16'h4000); cy(1'h1);
    t(6'h19, 16'h4001, 16'h0000, 16'h8002); cy(1'h0);
    t(6'h1A, 16'h0003, 16'h0000, 16'h0001); cy(1'h1);
    t(6'h1E, 16'h9999, 16'h0000, 16'h0000); cy(1'h1);
    t(6'h1F, 16'h0100, 16'h0001, 16'h0098); cy(1'h0);
    t(6'h20, 16'h1234, 16'h0100, 16'h3400); rd(8'h10); ck(d, 32'h12);
    t(6'h21, 16'h1000, 16'h0003, 16'h0333); rd(8'h10); ck(d, 32'h1);
    t(6'h26, 16'h9999, 16'h0000, 16'h0000);
    t(6'h27, 16'h0000, 16'h0000, 16'h9999);
    op(6'h14, 16'h8000, 16'h7FFF); rd(8'h14); ck(d[3:1], 32'h1);
    op(6'h14, 16'h0001, 16'h0002); rd(8'h14); ck(d[3:1], 32'h4);
    rd(8'h0C); ck(d, 32'h9999);
    op(6'h0C, 16'h1, 16'h0); op(6'h0C, 16'h1, 16'h0);
    rd(8'h18); ck(d, 1);
    op(6'h0C, 16'h0, 16'h0); op(6'h0C, 16'h2, 16'h0);
    rd(8'h18); ck(d, 0);
    op(6'h0D, 16'h1, 16'h0); rd(8'h14); ck(d[4], 32'h1);
    op(6'h0D, 16'h1, 16'h0); rd(8'h14); ck(d[4], 32'h0);
    op(6'h0E, 16'h1, 16'h0); op(6'h0E, 16'h0, 16'h0);
    rd(8'h14); ck(d[5], 1);
    wr(8'h1C, 16'h2); wr(8'h20, 16'hAAAA); wr(8'h1C, 16'h3);
    op(6'h10, 16'h2, 16'h3); rd(8'h20); ck(d, 32'hAAAA);
    wr(8'h1C, 16'h2); rd(8'h20); ck(d, 32'h0);
    wr(8'h3C, 16'h1234); ck(bs, 32'h2);
    rd(8'h3C); ck({rs, d[15:0]}, 32'h20000);
    summarize;
  end
endmodule // tb_top
`default_nettype wire
